/* verilog/bpc_pkg.sv */
// Purpose: Shared constants and carriers for the commutation PWM stage
// Assumes: 16-bit register port, four submodules, synchronous reset
// Notes: Per-submodule registers sit at addr[6:5] = submodule, addr[7] = 0
package bpc_pkg;
  localparam int SM_NUM = 4;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int CMP_NUM = 7;
  localparam int FLT_NUM = 4;
  // Per-submodule offsets in addr[4:0]
  localparam logic [4:0] OFF_CNT = 5'h00;
  localparam logic [4:0] OFF_INIT = 5'h01;
  localparam logic [4:0] OFF_COMPARE_VALUE_ZERO = 5'h02;
  localparam logic [4:0] OFF_SUBMODULE_CONTROL2_REG = 5'h09;
  localparam logic [4:0] OFF_OUTPUT_CONTROL_REG = 5'h0A;
  localparam logic [4:0] OFF_FAULT_DISABLE_MAP = 5'h0B;
  localparam logic [4:0] OFF_TRIGGER_CONTROL_REG = 5'h0C;
  localparam logic [4:0] OFF_SUBMODULE_IRQ_ENABLE_REG = 5'h0D;
  localparam logic [4:0] OFF_STS = 5'h0E;
  localparam logic [4:0] OFF_DT0 = 5'h0F;
  localparam logic [4:0] OFF_DT1 = 5'h10;
  // Global offsets
  localparam logic [7:0] ADR_OUTPUT_ENABLE_REG = 8'h80;
  localparam logic [7:0] ADR_MASK = 8'h81;
  localparam logic [7:0] ADR_SOFTWARE_OUTPUT_REG = 8'h82;
  localparam logic [7:0] ADR_SRCSEL = 8'h83;
  localparam logic [7:0] ADR_MASTER_CONTROL_REG = 8'h84;
  localparam logic [7:0] ADR_FAULT_CONTROL_REG = 8'h85;
  localparam logic [7:0] ADR_FAULT_STATUS_REG = 8'h86;
  // Field positions
  localparam int SUBMODULE_CONTROL2_REG_FRC_RLD_EN = 2;
  localparam int SUBMODULE_CONTROL2_REG_FRC_EXT_EN = 3;
  localparam int SUBMODULE_CONTROL2_REG_FORCE = 6;
  localparam int SUBMODULE_CONTROL2_REG_INDEPENDENT_MODE_BIT = 13;
  localparam int OUTPUT_CONTROL_REG_CHANNEL_A_POLARITY = 10;
  localparam int OUTPUT_CONTROL_REG_CHANNEL_B_POLARITY = 9;
  localparam int OUTPUT_CONTROL_REG_CHANNEL_X_POLARITY = 8;
  localparam int OUTPUT_CONTROL_REG_AFS = 4;
  localparam int OUTPUT_CONTROL_REG_BFS = 2;
  localparam int OUTPUT_CONTROL_REG_XFS = 0;
  localparam int FAULT_DISABLE_MAP_A_LSB = 0;
  localparam int FAULT_DISABLE_MAP_B_LSB = 4;
  localparam int FAULT_DISABLE_MAP_X_LSB = 8;
  localparam int TRIGGER_CONTROL_REG_TRIG0 = 0;
  localparam int IRQ_RELOAD = 12;
  localparam int IRQ_RLDERR = 13;
  localparam int OUT_X_LSB = 0;
  localparam int OUT_B_LSB = 4;
  localparam int OUT_A_LSB = 8;
  localparam int MASTER_CONTROL_REG_LDOK_LSB = 0;
  localparam int MASTER_CONTROL_REG_RUN_LSB = 8;
  localparam int MASTER_CONTROL_REG_PAIR_INVERSION_SELECT_LSB = 12;
  localparam int FAULT_CONTROL_REG_FIE_LSB = 0;
  localparam logic [1:0] SRC_GEN = 2'h0;
  localparam logic [1:0] SRC_INV = 2'h1;
  localparam logic [DW-1:0] RST_WORD = 16'h0000;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } bpc_bus_req_t;

  typedef struct packed {
    logic [DW-1:0] cnt;
    logic [DW-1:0] init;
    logic [CMP_NUM-1:0][DW-1:0] val;
    logic [CMP_NUM-1:0][DW-1:0] val_buf;
    logic dirty;
    logic [DW-1:0] submodule_control2_reg;
    logic [DW-1:0] output_control_reg;
    logic [DW-1:0] fault_disable_map;
    logic [DW-1:0] trigger_control_reg;
    logic [DW-1:0] submodule_irq_enable_reg;
    logic [DW-1:0] sts;
    logic [DW-1:0] dt0;
    logic [DW-1:0] dt1;
    logic [DW-1:0] dtcnt;
    logic base_q;
    logic a_q;
    logic b_q;
    logic x_q;
    logic trig_q;
  } bpc_sm_t;

  typedef struct packed {
    bpc_sm_t [SM_NUM-1:0] sm;
    logic [DW-1:0] output_enable_reg;
    logic [DW-1:0] mask_buf;
    logic [DW-1:0] mask_act;
    logic [DW-1:0] sel_buf;
    logic [DW-1:0] sel_act;
    logic [2*SM_NUM-1:0] sw_buf;
    logic [2*SM_NUM-1:0] sw_act;
    logic [SM_NUM-1:0] pair_inversion_select_buf;
    logic [SM_NUM-1:0] pair_inversion_select_act;
    logic [SM_NUM-1:0] ldok;
    logic [SM_NUM-1:0] run;
    logic [FLT_NUM-1:0] fault_irq_enable_bits;
    logic [FLT_NUM-1:0] fault_flag_bits;
    logic [DW-1:0] rdata;
  } bpc_state_t;
endpackage

/* verilog/bpc_stage.sv */
// Purpose: Complementary PWM output stage for six-step brushless commutation
// Assumes: Inputs synchronous to clk, plain register port, read data one cycle late
// Notes: Output path is mask, fault, polarity, then output enable
// What this block does
// - Trigger zero fires when counter equals compare zero
// - Separate polarity bits make A, B, X active-low
// - Mapped active fault inputs disable each output
// - Disabled output takes fault level before polarity
// - Fault flags are write-one-to-clear
// - Reload, fault and reload-error interrupt sources exist
// - Compare matches 0 to 6 raise selectable interrupts
// - Interrupt enables and requests are per submodule, except the global fault irq
// - Fault enable bits gate fault flag interrupts
// - Run bit enables counter, else counter held at init
// - Output enable register gates each A, B, X pin
// - Commutation controls buffered until force-out event
// - Force-out from software bit, external input, reload
// - Mask forces chosen outputs inactive, even complementary
// - Pair 23 source field: generated, inverted, software
// - Inversion select chooses 23 or 45 pair
// - All mask bits set stops every output
// - Pairs complementary with dead time unless independent
// - Dead time counted in clock cycles, two counts
// - Edge-aligned: count to compare one, edges two/three
`timescale 1ns/1ps
module bpc_stage (
  input wire logic clk,
  input wire logic srst,
  input wire bpc_pkg::bpc_bus_req_t bus_req,
  output logic [bpc_pkg::DW-1:0] rd_data,
  input wire logic [bpc_pkg::FLT_NUM-1:0] fault_input_n,
  input wire logic external_force_input,
  output logic [bpc_pkg::SM_NUM-1:0] pwm_a,
  output logic [bpc_pkg::SM_NUM-1:0] pwm_b,
  output logic [bpc_pkg::SM_NUM-1:0] pwm_x,
  output logic [bpc_pkg::SM_NUM-1:0] pwm_a_en,
  output logic [bpc_pkg::SM_NUM-1:0] pwm_b_en,
  output logic [bpc_pkg::SM_NUM-1:0] pwm_x_en,
  output logic [bpc_pkg::SM_NUM-1:0] trigger_out_zero,
  output logic [bpc_pkg::SM_NUM-1:0] sm_irq,
  output logic fault_irq
);
  import bpc_pkg::*;

  bpc_state_t st_r;
  bpc_state_t st_nxt;

  // Source selection shared by both signal pairs
  function automatic logic pick_src(input logic [1:0] sel, input logic gen, input logic sw);
    logic r;
    r = sw;
    if (sel == SRC_GEN) begin
      r = gen;
    end else if (sel == SRC_INV) begin
      r = ~gen;
    end
    return r;
  endfunction

  // Window compare used for both edge pairs
  function automatic logic in_window(input logic [DW-1:0] c, input logic [DW-1:0] lo,
                                     input logic [DW-1:0] hi);
    return (c >= lo) && (c < hi);
  endfunction

  // Per-submodule window, shared by reads and writes
  function automatic logic sm_hit(input logic [AW-1:0] a, input int idx);
    return !a[7] && (a[6:5] == 2'(idx));
  endfunction

  // Seven compare value slots in a row
  function automatic logic is_val_off(input logic [4:0] o);
    return (o >= OFF_COMPARE_VALUE_ZERO) && (o < OFF_COMPARE_VALUE_ZERO + 5'(CMP_NUM));
  endfunction

  // Any mapped fault input active
  function automatic logic fault_hit(input logic [FLT_NUM-1:0] flt,
                                     input logic [FLT_NUM-1:0] map);
    return |(flt & map);
  endfunction

  // Counter at the top of its period, so a reload is due
  function automatic logic at_reload(input bpc_sm_t s, input logic run);
    return run && (s.cnt == s.val[1]);
  endfunction

  always_comb begin
    logic wr_sm;
    logic rd_sm;
    logic [4:0] off;
    logic reload;
    logic force_ev;
    logic frc_wr;
    logic p23;
    logic p45;
    logic s23;
    logic s45;
    logic base;
    logic a_raw;
    logic b_raw;
    logic x_raw;
    logic independent_mode_bit;
    logic [DW-1:0] wd;
    wr_sm = 1'b0;
    rd_sm = 1'b0;
    off = bus_req.addr[4:0];
    reload = 1'b0;
    force_ev = 1'b0;
    frc_wr = 1'b0;
    p23 = 1'b0;
    p45 = 1'b0;
    s23 = 1'b0;
    s45 = 1'b0;
    base = 1'b0;
    a_raw = 1'b0;
    b_raw = 1'b0;
    x_raw = 1'b0;
    independent_mode_bit = 1'b0;
    wd = bus_req.wdata;
    st_nxt = st_r;
    st_nxt.rdata = RST_WORD;

    // Force-out sources gathered from submodule 0
    frc_wr = bus_req.wr && (bus_req.addr == {1'b0, 2'h0, OFF_SUBMODULE_CONTROL2_REG}) && wd[SUBMODULE_CONTROL2_REG_FORCE];
    force_ev = frc_wr;
    if (st_r.sm[0].submodule_control2_reg[SUBMODULE_CONTROL2_REG_FRC_EXT_EN] && external_force_input) begin
      force_ev = 1'b1;
    end
    if (st_r.sm[0].submodule_control2_reg[SUBMODULE_CONTROL2_REG_FRC_RLD_EN] && at_reload(st_r.sm[0], st_r.run[0])) begin
      force_ev = 1'b1;
    end

    // Global register writes and reads
    if (bus_req.wr) begin
      case (bus_req.addr)
        ADR_OUTPUT_ENABLE_REG: st_nxt.output_enable_reg = wd;
        ADR_MASK: st_nxt.mask_buf = wd;
        ADR_SOFTWARE_OUTPUT_REG: st_nxt.sw_buf = wd[2*SM_NUM-1:0];
        ADR_SRCSEL: st_nxt.sel_buf = wd;
        ADR_MASTER_CONTROL_REG: begin
          st_nxt.ldok = wd[MASTER_CONTROL_REG_LDOK_LSB +: SM_NUM];
          st_nxt.run = wd[MASTER_CONTROL_REG_RUN_LSB +: SM_NUM];
          st_nxt.pair_inversion_select_buf = wd[MASTER_CONTROL_REG_PAIR_INVERSION_SELECT_LSB +: SM_NUM];
        end
        ADR_FAULT_CONTROL_REG: st_nxt.fault_irq_enable_bits = wd[FAULT_CONTROL_REG_FIE_LSB +: FLT_NUM];
        ADR_FAULT_STATUS_REG: st_nxt.fault_flag_bits = st_r.fault_flag_bits & ~wd[FLT_NUM-1:0];
        default: st_nxt.output_enable_reg = st_nxt.output_enable_reg;
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADR_OUTPUT_ENABLE_REG: st_nxt.rdata = st_r.output_enable_reg;
        ADR_MASK: st_nxt.rdata = st_r.mask_buf;
        ADR_SOFTWARE_OUTPUT_REG: st_nxt.rdata[2*SM_NUM-1:0] = st_r.sw_buf;
        ADR_SRCSEL: st_nxt.rdata = st_r.sel_buf;
        ADR_MASTER_CONTROL_REG: begin
          st_nxt.rdata[MASTER_CONTROL_REG_LDOK_LSB +: SM_NUM] = st_r.ldok;
          st_nxt.rdata[MASTER_CONTROL_REG_RUN_LSB +: SM_NUM] = st_r.run;
          st_nxt.rdata[MASTER_CONTROL_REG_PAIR_INVERSION_SELECT_LSB +: SM_NUM] = st_r.pair_inversion_select_buf;
        end
        ADR_FAULT_CONTROL_REG: st_nxt.rdata[FAULT_CONTROL_REG_FIE_LSB +: FLT_NUM] = st_r.fault_irq_enable_bits;
        ADR_FAULT_STATUS_REG: st_nxt.rdata[FLT_NUM-1:0] = st_r.fault_flag_bits;
        default: st_nxt.rdata = RST_WORD;
      endcase
    end

    // Fault flags latch after the clear, so a new fault wins
    st_nxt.fault_flag_bits = st_nxt.fault_flag_bits | fault_input_n;

    // All four commutation controls move together, never a mixed set
    if (force_ev) begin
      st_nxt.mask_act = st_r.mask_buf;
      st_nxt.sel_act = st_r.sel_buf;
      st_nxt.sw_act = st_r.sw_buf;
      st_nxt.pair_inversion_select_act = st_r.pair_inversion_select_buf;
    end

    for (int i = 0; i < SM_NUM; i++) begin
      wr_sm = bus_req.wr && sm_hit(bus_req.addr, i);
      rd_sm = bus_req.rd && sm_hit(bus_req.addr, i);

      // Submodule register writes
      if (wr_sm) begin
        if (off == OFF_INIT) begin
          st_nxt.sm[i].init = wd;
        end else if (is_val_off(off)) begin
          st_nxt.sm[i].val_buf[3'(off - OFF_COMPARE_VALUE_ZERO)] = wd;
          st_nxt.sm[i].dirty = 1'b1;
        end else if (off == OFF_SUBMODULE_CONTROL2_REG) begin
          st_nxt.sm[i].submodule_control2_reg = wd;
          // Force is a strobe, never stored, so it reads back as zero
          st_nxt.sm[i].submodule_control2_reg[SUBMODULE_CONTROL2_REG_FORCE] = 1'b0;
        end else if (off == OFF_OUTPUT_CONTROL_REG) begin
          st_nxt.sm[i].output_control_reg = wd;
        end else if (off == OFF_FAULT_DISABLE_MAP) begin
          st_nxt.sm[i].fault_disable_map = wd;
        end else if (off == OFF_TRIGGER_CONTROL_REG) begin
          st_nxt.sm[i].trigger_control_reg = wd;
        end else if (off == OFF_SUBMODULE_IRQ_ENABLE_REG) begin
          st_nxt.sm[i].submodule_irq_enable_reg = wd;
        end else if (off == OFF_STS) begin
          // Flag sets further down win over this clear
          st_nxt.sm[i].sts = st_r.sm[i].sts & ~wd;
        end else if (off == OFF_DT0) begin
          st_nxt.sm[i].dt0 = wd;
        end else if (off == OFF_DT1) begin
          st_nxt.sm[i].dt1 = wd;
        end
      end

      // Submodule register reads
      if (rd_sm) begin
        if (off == OFF_CNT) begin
          st_nxt.rdata = st_r.sm[i].cnt;
        end else if (off == OFF_INIT) begin
          st_nxt.rdata = st_r.sm[i].init;
        end else if (is_val_off(off)) begin
          st_nxt.rdata = st_r.sm[i].val_buf[3'(off - OFF_COMPARE_VALUE_ZERO)];
        end else if (off == OFF_SUBMODULE_CONTROL2_REG) begin
          st_nxt.rdata = st_r.sm[i].submodule_control2_reg;
        end else if (off == OFF_OUTPUT_CONTROL_REG) begin
          st_nxt.rdata = st_r.sm[i].output_control_reg;
        end else if (off == OFF_FAULT_DISABLE_MAP) begin
          st_nxt.rdata = st_r.sm[i].fault_disable_map;
        end else if (off == OFF_TRIGGER_CONTROL_REG) begin
          st_nxt.rdata = st_r.sm[i].trigger_control_reg;
        end else if (off == OFF_SUBMODULE_IRQ_ENABLE_REG) begin
          st_nxt.rdata = st_r.sm[i].submodule_irq_enable_reg;
        end else if (off == OFF_STS) begin
          st_nxt.rdata = st_r.sm[i].sts;
        end else if (off == OFF_DT0) begin
          st_nxt.rdata = st_r.sm[i].dt0;
        end else if (off == OFF_DT1) begin
          st_nxt.rdata = st_r.sm[i].dt1;
        end
      end

      // Counter runs from init up to compare one
      reload = at_reload(st_r.sm[i], st_r.run[i]);
      if (!st_r.run[i]) begin
        st_nxt.sm[i].cnt = st_r.sm[i].init;
      end else if (reload) begin
        st_nxt.sm[i].cnt = st_r.sm[i].init;
      end else begin
        st_nxt.sm[i].cnt = DW'(st_r.sm[i].cnt + 1'b1);
      end

      // Compare values only move as a confirmed set at reload
      if (reload) begin
        st_nxt.sm[i].sts[IRQ_RELOAD] = 1'b1;
        if (st_r.ldok[i]) begin
          st_nxt.sm[i].val = st_r.sm[i].val_buf;
          st_nxt.sm[i].dirty = 1'b0;
          st_nxt.ldok[i] = 1'b0;
        end else if (st_r.sm[i].dirty) begin
          st_nxt.sm[i].sts[IRQ_RLDERR] = 1'b1;
        end
      end
      // Only a running counter can match, a held one raises nothing
      for (int k = 0; k < CMP_NUM; k++) begin
        if (st_r.run[i] && st_r.sm[i].cnt == st_r.sm[i].val[k]) begin
          st_nxt.sm[i].sts[k] = 1'b1;
        end
      end

      st_nxt.sm[i].trig_q = st_r.sm[i].trigger_control_reg[TRIGGER_CONTROL_REG_TRIG0] && st_r.run[i] &&
                            (st_r.sm[i].cnt == st_r.sm[i].val[0]);

      // Signal generation and source selection
      p23 = in_window(st_r.sm[i].cnt, st_r.sm[i].val[2], st_r.sm[i].val[3]);
      p45 = in_window(st_r.sm[i].cnt, st_r.sm[i].val[4], st_r.sm[i].val[5]);
      s23 = pick_src(st_r.sel_act[4*i+2 +: 2], p23, st_r.sw_act[2*i+1]);
      s45 = pick_src(st_r.sel_act[4*i +: 2], p45, st_r.sw_act[2*i]);
      base = st_r.pair_inversion_select_act[i] ? s45 : s23;
      independent_mode_bit = st_r.sm[i].submodule_control2_reg[SUBMODULE_CONTROL2_REG_INDEPENDENT_MODE_BIT];

      // Each edge holds both switches off for its own count
      // A base change inside the dead band restarts it, so short pulses vanish
      st_nxt.sm[i].base_q = base;
      if (base != st_r.sm[i].base_q) begin
        st_nxt.sm[i].dtcnt = base ? st_r.sm[i].dt0 : st_r.sm[i].dt1;
      end else if (st_r.sm[i].dtcnt != RST_WORD) begin
        st_nxt.sm[i].dtcnt = DW'(st_r.sm[i].dtcnt - 1'b1);
      end
      if (independent_mode_bit) begin
        a_raw = s23;
        b_raw = s45;
      end else begin
        a_raw = st_r.sm[i].base_q && (st_r.sm[i].dtcnt == RST_WORD);
        b_raw = !st_r.sm[i].base_q && (st_r.sm[i].dtcnt == RST_WORD);
      end
      // X stays high until the count reaches compare zero
      x_raw = st_r.sm[i].cnt < st_r.sm[i].val[0];

      // Masking works in complementary mode too
      a_raw = a_raw && !st_r.mask_act[OUT_A_LSB + i];
      b_raw = b_raw && !st_r.mask_act[OUT_B_LSB + i];
      x_raw = x_raw && !st_r.mask_act[OUT_X_LSB + i];

      // Fault level replaces the signal ahead of polarity
      if (fault_hit(fault_input_n, st_r.sm[i].fault_disable_map[FAULT_DISABLE_MAP_A_LSB +: FLT_NUM])) begin
        a_raw = st_r.sm[i].output_control_reg[OUTPUT_CONTROL_REG_AFS];
      end
      if (fault_hit(fault_input_n, st_r.sm[i].fault_disable_map[FAULT_DISABLE_MAP_B_LSB +: FLT_NUM])) begin
        b_raw = st_r.sm[i].output_control_reg[OUTPUT_CONTROL_REG_BFS];
      end
      if (fault_hit(fault_input_n, st_r.sm[i].fault_disable_map[FAULT_DISABLE_MAP_X_LSB +: FLT_NUM])) begin
        x_raw = st_r.sm[i].output_control_reg[OUTPUT_CONTROL_REG_XFS];
      end

      st_nxt.sm[i].a_q = a_raw ^ st_r.sm[i].output_control_reg[OUTPUT_CONTROL_REG_CHANNEL_A_POLARITY];
      st_nxt.sm[i].b_q = b_raw ^ st_r.sm[i].output_control_reg[OUTPUT_CONTROL_REG_CHANNEL_B_POLARITY];
      st_nxt.sm[i].x_q = x_raw ^ st_r.sm[i].output_control_reg[OUTPUT_CONTROL_REG_CHANNEL_X_POLARITY];
    end
  end

  // Reset clears every run bit, so each counter restarts from init
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    // Read data is zero outside the cycle after a read
    rd_data = st_r.rdata;
    fault_irq = |(st_r.fault_flag_bits & st_r.fault_irq_enable_bits);
    for (int i = 0; i < SM_NUM; i++) begin
      pwm_a[i] = st_r.sm[i].a_q;
      pwm_b[i] = st_r.sm[i].b_q;
      pwm_x[i] = st_r.sm[i].x_q;
      pwm_a_en[i] = st_r.output_enable_reg[OUT_A_LSB + i];
      pwm_b_en[i] = st_r.output_enable_reg[OUT_B_LSB + i];
      pwm_x_en[i] = st_r.output_enable_reg[OUT_X_LSB + i];
      trigger_out_zero[i] = st_r.sm[i].trig_q;
      sm_irq[i] = |(st_r.sm[i].sts & st_r.sm[i].submodule_irq_enable_reg);
    end
  end
endmodule

/* verification/bpc_inverter.sv */
// Purpose: Behavioural half-bridge power stage on legs 0 to 2
// Assumes: Gate on when pin level and its enable are both high
// Notes: Overcurrent follows an injected fault or a shorted leg
`timescale 1ns/1ps
module bpc_inverter (
  input wire logic [bpc_pkg::SM_NUM-1:0] pwm_a,
  input wire logic [bpc_pkg::SM_NUM-1:0] pwm_b,
  input wire logic [bpc_pkg::SM_NUM-1:0] pwm_a_en,
  input wire logic [bpc_pkg::SM_NUM-1:0] pwm_b_en,
  input wire logic inject_oc,
  output logic shoot,
  output logic oc
);
  import bpc_pkg::*;
  // Top and bottom of one leg on together shorts the bus
  assign shoot = |(pwm_a[2:0] & pwm_a_en[2:0] & pwm_b[2:0] & pwm_b_en[2:0]);
  assign oc = inject_oc | shoot;
endmodule

/* verification/bpc_chk_assertions.sv */
// Purpose: Port checks for the commutation stage
// Assumes: Shadows follow register writes seen on the port
// Notes: Only submodule 0 is shadowed, to stay small
`timescale 1ns/1ps
module bpc_chk (
  input wire logic clk,
  input wire logic srst,
  input wire bpc_pkg::bpc_bus_req_t bus_req,
  input wire logic [bpc_pkg::FLT_NUM-1:0] fault_input_n,
  input wire logic [bpc_pkg::SM_NUM-1:0] pwm_a,
  input wire logic [bpc_pkg::SM_NUM-1:0] pwm_a_en,
  input wire logic [bpc_pkg::SM_NUM-1:0] pwm_b_en,
  input wire logic [bpc_pkg::SM_NUM-1:0] pwm_x_en,
  input wire logic [bpc_pkg::SM_NUM-1:0] trigger_out_zero,
  input wire logic [bpc_pkg::SM_NUM-1:0] sm_irq,
  input wire logic fault_irq
);
  import bpc_pkg::*;
  logic w;
  logic [3:0] fie_sh;
  logic [15:0] dmap_sh;
  logic [15:0] oct_sh;
  logic ten_sh;
  logic ien_sh;
  assign w = bus_req.wr;
  always_ff @(posedge clk) begin
    if (srst) begin
      fie_sh <= 4'h0;
      dmap_sh <= 16'h0000;
      oct_sh <= 16'h0000;
      ten_sh <= 1'b0;
      ien_sh <= 1'b0;
    end else if (w) begin
      if (bus_req.addr == ADR_FAULT_CONTROL_REG) fie_sh <= bus_req.wdata[3:0];
      if (bus_req.addr == 8'h0B) dmap_sh <= bus_req.wdata;
      if (bus_req.addr == 8'h0A) oct_sh <= bus_req.wdata;
      if (bus_req.addr == 8'h0C) ten_sh <= bus_req.wdata[0];
      // Over-approximate: any set bit may enable an irq
      if (bus_req.addr == 8'h0D) ien_sh <= |bus_req.wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_output_enable_reg_apply: assert property (
    w && bus_req.addr == ADR_OUTPUT_ENABLE_REG |=>
    {pwm_a_en, pwm_b_en, pwm_x_en} == $past(bus_req.wdata[11:0]))
    else $error("pin enables differ from written word");
  a_output_enable_reg_hold: assert property (
    !srst && !(w && bus_req.addr == ADR_OUTPUT_ENABLE_REG) |=> $stable({pwm_a_en, pwm_b_en, pwm_x_en}))
    else $error("pin enables moved without a write");
  a_flt_irq_set: assert property (
    !w && (|(fault_input_n & fie_sh)) |-> ##[1:2] fault_irq)
    else $error("enabled fault gave no fault irq");
  a_flt_irq_gate: assert property (
    fie_sh == 4'h0 |-> !fault_irq)
    else $error("fault irq while all enables are off");
  a_flt_clear: assert property (
    w && bus_req.addr == ADR_FAULT_STATUS_REG && bus_req.wdata[3:0] == 4'hF && fault_input_n == 4'h0
    |=> !fault_irq)
    else $error("fault flags survived a clear");
  a_irq_gate: assert property (
    !ien_sh |-> !sm_irq[0])
    else $error("submodule irq while its enables are off");
  a_flt_disable: assert property (
    !w && (|(fault_input_n & dmap_sh[3:0])) && oct_sh[5:4] == 2'h0
    |=> pwm_a[0] == oct_sh[10])
    else $error("faulted output not at off level");
  a_trig_gate: assert property (
    !ten_sh && !$past(ten_sh) |-> !trigger_out_zero[0])
    else $error("trigger while trigger enable is off");
  c_trig: cover property (trigger_out_zero[0]);
  c_firq: cover property (fault_irq);
  c_smirq: cover property (sm_irq[0]);
endmodule
bind bpc_stage bpc_chk i_chk (.clk(clk), .srst(srst), .bus_req(bus_req),
  .fault_input_n(fault_input_n), .pwm_a(pwm_a), .pwm_a_en(pwm_a_en), .pwm_b_en(pwm_b_en),
  .pwm_x_en(pwm_x_en), .trigger_out_zero(trigger_out_zero), .sm_irq(sm_irq),
  .fault_irq(fault_irq));

/* verification/tb.sv */
// Purpose: Self-checking bench for the commutation stage
// Assumes: Submodule 0 runs a 33-cycle edge-aligned period
// Notes: Steady levels are checked so no check hangs on pwm phase
`timescale 1ns/1ps
module tb;
  import bpc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  bpc_bus_req_t bus = '0;
  logic [DW-1:0] rd_data;
  logic [3:0] flt = 4'h0;
  logic ext = 1'b0;
  logic inj = 1'b0;
  logic oc;
  logic shoot;
  logic [SM_NUM-1:0] pa, pb, px, ae, be, xe, trg, irq;
  logic firq;
  logic [DW-1:0] d;
  int fails = 0;
  int n_compared = 0;
  int k;
  always #12.5 clk = ~clk;
  bpc_stage i_bpc_stage (.clk(clk), .srst(srst), .bus_req(bus), .rd_data(rd_data),
    .fault_input_n(flt | {3'h0, oc}), .external_force_input(ext), .pwm_a(pa), .pwm_b(pb),
    .pwm_x(px), .pwm_a_en(ae), .pwm_b_en(be), .pwm_x_en(xe), .trigger_out_zero(trg),
    .sm_irq(irq), .fault_irq(firq));
  bpc_inverter i_bpc_inverter (.pwm_a(pa), .pwm_b(pb), .pwm_a_en(ae), .pwm_b_en(be),
    .inject_oc(inj), .shoot(shoot), .oc(oc));
  task automatic chk(string nm, logic [DW-1:0] e, logic [DW-1:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(negedge clk) if (!srst) chk("leg short", 16'h0000, {15'h0, shoot});
  task wr(logic [AW-1:0] a, logic [DW-1:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task rd(logic [AW-1:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask
  task lvl(string nm, logic ea, logic eb);
    repeat (14) @(posedge clk);
    @(negedge clk);
    chk({nm, " a"}, {15'h0, ea}, {15'h0, pa[0]});
    chk({nm, " b"}, {15'h0, eb}, {15'h0, pb[0]});
  endtask
  task frc_ext;
    @(posedge clk);
    ext <= 1'b1;
    @(posedge clk);
    ext <= 1'b0;
  endtask
  task t_regs;
    rd(8'h00);
    chk("count idle", 16'h0000, d);
    wr(ADR_OUTPUT_ENABLE_REG, 16'h0770);
    rd(ADR_OUTPUT_ENABLE_REG);
    chk("output_enable_reg", 16'h0770, d);
    chk("pin en", 16'h0770, {4'h0, ae, be, xe});
    rd(8'hFF);
    chk("unmapped", 16'h0000, d);
    $display("regs done");
  endtask
  task t_trig;
    wr(8'h02, 16'h0018);
    wr(8'h03, 16'h0020);
    wr(8'h05, 16'h0030);
    wr(8'h0F, 16'h0005);
    wr(8'h10, 16'h0005);
    wr(8'h0C, 16'h0001);
    wr(8'h09, 16'h0008);
    wr(ADR_MASTER_CONTROL_REG, 16'h0101);
    for (k = 0; k < 200 && trg[0] !== 1'b1; k++) @(negedge clk);
    chk("trig at start", 16'h0001, {15'h0, trg[0]});
    if (trg[0] !== 1'b1) close_out;
    // Active compare values start at zero, so the first match comes at run start
    @(negedge clk);
    for (k = 1; k < 200 && trg[0] !== 1'b1; k++) @(negedge clk);
    chk("trig offset", 16'h0019, k[15:0]);
    chk("trig seen", 16'h0001, {15'h0, trg[0]});
    if (trg[0] !== 1'b1) close_out;
    @(negedge clk);
    chk("trig width", 16'h0000, {15'h0, trg[0]});
    for (k = 1; k < 200 && trg[0] !== 1'b1; k++) @(negedge clk);
    chk("trig period", 16'h0021, k[15:0]);
    if (k >= 200) close_out;
    rd(8'h0E);
    chk("flags", 16'h1001, d & 16'h1001);
    wr(8'h0D, 16'h0001);
    @(negedge clk);
    chk("sm irq", 16'h0001, {12'h0, irq});
    wr(8'h0D, 16'h0000);
    wr(8'h02, 16'h0010);
    repeat (40) @(posedge clk);
    rd(8'h0E);
    chk("reload error", 16'h2000, d & 16'h2000);
    $display("trigger done");
  endtask
  task t_force;
    lvl("gen", 1'b1, 1'b0);
    wr(ADR_SRCSEL, 16'h0004);
    lvl("buffered", 1'b1, 1'b0);
    wr(8'h09, 16'h0048);
    k = 0;
    repeat (20) begin
      @(negedge clk);
      if (pa[0] === 1'b0 && pb[0] === 1'b0) k++;
    end
    chk("dead gap", 16'h0001, {15'h0, k >= 5});
    lvl("inverted", 1'b0, 1'b1);
    wr(ADR_SRCSEL, 16'h0000);
    wr(ADR_MASK, 16'h0110);
    wr(ADR_MASTER_CONTROL_REG, 16'h1100);
    lvl("held", 1'b0, 1'b1);
    frc_ext;
    lvl("masked", 1'b0, 1'b0);
    wr(ADR_MASK, 16'h0000);
    frc_ext;
    lvl("pair45", 1'b0, 1'b1);
    wr(ADR_MASTER_CONTROL_REG, 16'h0100);
    wr(ADR_MASK, 16'h0FFF);
    wr(8'h09, 16'h0048);
    lvl("all masked", 1'b0, 1'b0);
    k = 0;
    repeat (40) begin
      @(negedge clk);
      if (px[0] !== 1'b0) k++;
    end
    chk("x masked", 16'h0000, k[15:0]);
    $display("force done");
  endtask
  task t_fault;
    wr(ADR_MASK, 16'h0000);
    wr(8'h09, 16'h0048);
    wr(8'h0A, 16'h0400);
    lvl("active low", 1'b0, 1'b0);
    wr(8'h0B, 16'hF033);
    wr(ADR_FAULT_CONTROL_REG, 16'h0003);
    @(posedge clk);
    inj <= 1'b1;
    repeat (3) @(negedge clk);
    chk("fault a", 16'h0001, {15'h0, pa[0]});
    chk("fault b", 16'h0000, {15'h0, pb[0]});
    chk("fault irq", 16'h0001, {15'h0, firq});
    @(posedge clk);
    inj <= 1'b0;
    wr(ADR_FAULT_STATUS_REG, 16'h000F);
    rd(ADR_FAULT_STATUS_REG);
    chk("flags cleared", 16'h0000, d & 16'h000F);
    @(posedge clk);
    flt <= 4'h4;
    repeat (3) @(negedge clk);
    chk("unmapped fault a", 16'h0000, {15'h0, pa[0]});
    chk("gated irq", 16'h0000, {15'h0, firq});
    @(posedge clk);
    flt <= 4'h0;
    rd(ADR_FAULT_STATUS_REG);
    chk("fault2 flag", 16'h0004, d & 16'h000F);
    wr(ADR_FAULT_STATUS_REG, 16'h000F);
    wr(ADR_MASTER_CONTROL_REG, 16'h0000);
    rd(8'h00);
    chk("count stopped", 16'h0000, d);
    $display("fault done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_trig;
    t_force;
    t_fault;
    close_out;
  end
endmodule
